/* design/brac_top.sv */
// Bus request acceptance and bus status pin driver.
// Assumes the core gives cycle kind and end-of-cycle pulses on I_CLK.
// Function
// - Wait honoured only in normal, wait, ack, DMA
// - Refresh starts at end of normal cycle
// - Refresh from ack/DMA; refused in others
// - DMA during refresh waits one cycle after
// - DMA starts at cycle end; refused asleep
// - DMA held through release, starts after
// - Hold releases bus; refused in wait/refresh
// - Stay released while hold; accept when asleep
// - Irq after instruction in normal or wait
// - Irq wakes sleep to normal
// - Irq wakes system stop to normal
// - First fetch pin levels
// - Later fetches set fetch status high
// - Memory, I/O, internal cycle strobes
// - Refresh cycle strobes
// - Nmi and line 0 ack strobes
// - Other acks keep strobes high
// - Bus release floats and grants
// - Halt and sleep pin levels
`timescale 1ns/1ps
module brac_top #(
    parameter int ADDR_W = 16
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_WAIT_N,
    input wire logic I_BUS_HOLD_REQUEST_N,
    input wire logic I_DMA_REQUEST_CH0,
    input wire logic I_DMA_REQUEST_CH1,
    input wire logic I_IRQ_LINE_0,
    input wire logic I_IRQ_LINE_1,
    input wire logic I_IRQ_LINE_2,
    input wire logic I_REFRESH_DUE,
    input wire logic I_MC_END,
    input wire logic I_INSN_END,
    input wire logic I_DMA_DONE,
    input wire logic I_ACK_DONE,
    input wire logic I_SLEEP_CMD,
    input wire logic I_STOP_CMD,
    input wire logic I_IO_FREEZE_MODE,
    input wire logic [3:0] I_CYCLE_KIND,
    input wire logic [ADDR_W-1:0] I_ADDR,
    output logic O_OPCODE_FETCH_STROBE_N,
    output logic O_MEMORY_REQUEST_N,
    output logic O_MEMORY_REQUEST_OE,
    output logic O_IO_REQUEST_N,
    output logic O_IO_REQUEST_OE,
    output logic O_READ_N,
    output logic O_READ_OE,
    output logic O_WRITE_N,
    output logic O_WRITE_OE,
    output logic O_REFRESH_STROBE_N,
    output logic O_SUSPEND_N,
    output logic O_BUS_HOLD_GRANT_N,
    output logic O_FIRST_FETCH_STATUS,
    output logic [ADDR_W-1:0] O_ADDR,
    output logic O_ADDR_OE,
    output logic O_DATA_OE,
    output logic O_WAIT_STRETCH,
    output logic O_IRQ_TAKEN,
    output logic [7:0] O_STATE
);

    // Two-stage synchronisers for pin inputs; each pin has its own pair
    // so no gate ever sees a level that is still settling
    logic [6:0] pin_meta_reg;
    logic [6:0] pin_sync_reg;
    logic [6:0] pin_raw;
    assign pin_raw = {I_WAIT_N, I_BUS_HOLD_REQUEST_N, I_DMA_REQUEST_CH0,
                      I_DMA_REQUEST_CH1, I_IRQ_LINE_0, I_IRQ_LINE_1,
                      I_IRQ_LINE_2};
    // Reset to idle pin levels so no false request follows reset
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pin_meta_reg <= brac_pkg::PIN_IDLE;
            pin_sync_reg <= brac_pkg::PIN_IDLE;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic wait_req;
    logic hold_req;
    logic dma_req;
    logic irq_req;
    assign wait_req = !pin_sync_reg[6];
    assign hold_req = !pin_sync_reg[5];
    assign dma_req = pin_sync_reg[4] | pin_sync_reg[3];
    // Lines are merged only after the flops, never before
    assign irq_req = pin_sync_reg[2] | pin_sync_reg[1] | pin_sync_reg[0];

    brac_pkg::brac_state_type state_reg;
    brac_pkg::brac_state_type state_next;
    logic dma_pend_reg;
    logic dma_pend_next;
    logic dma_gap_reg;
    logic dma_gap_next;
    logic irq_take;

    // Request acceptance per state; a held DMA request survives refresh
    // and release so it is not dropped by the other bus owner.
    always_comb begin
        state_next = state_reg;
        dma_pend_next = dma_pend_reg;
        dma_gap_next = dma_gap_reg;
        irq_take = 1'b0;
        case (state_reg)
            brac_pkg::ST_NORMAL: begin
                if (wait_req) begin
                    state_next = brac_pkg::ST_WAIT;
                end else if (I_MC_END && dma_gap_reg) begin
                    dma_gap_next = 1'b0;
                    state_next = brac_pkg::ST_DMA;
                end else if (I_MC_END && I_REFRESH_DUE) begin
                    state_next = brac_pkg::ST_REFRESH;
                end else if (I_MC_END && hold_req) begin
                    state_next = brac_pkg::ST_RELEASE;
                end else if (I_MC_END && dma_req) begin
                    state_next = brac_pkg::ST_DMA;
                end else if (I_INSN_END && irq_req) begin
                    irq_take = 1'b1;
                    state_next = brac_pkg::ST_ACK;
                end else if (I_MC_END && I_STOP_CMD) begin
                    state_next = brac_pkg::ST_STOP;
                end else if (I_MC_END && I_SLEEP_CMD) begin
                    state_next = brac_pkg::ST_SLEEP;
                end
            end
            brac_pkg::ST_WAIT: begin
                // Refresh and hold are refused while stretched
                // Irq is only flagged; the sequencer runs the acknowledge
                if (I_INSN_END && irq_req) begin
                    irq_take = 1'b1;
                end
                if (!wait_req) begin
                    state_next = brac_pkg::ST_NORMAL;
                end else if (I_MC_END && dma_req) begin
                    state_next = brac_pkg::ST_DMA;
                end
            end
            brac_pkg::ST_REFRESH: begin
                if (dma_req) begin
                    dma_pend_next = 1'b1;
                end
                if (I_MC_END) begin
                    dma_gap_next = dma_pend_reg | dma_req;
                    dma_pend_next = 1'b0;
                    state_next = brac_pkg::ST_NORMAL;
                end
            end
            brac_pkg::ST_ACK: begin
                if (I_MC_END && I_REFRESH_DUE) begin
                    state_next = brac_pkg::ST_REFRESH;
                end else if (I_MC_END && hold_req) begin
                    state_next = brac_pkg::ST_RELEASE;
                end else if (I_MC_END && dma_req) begin
                    state_next = brac_pkg::ST_DMA;
                end else if (I_ACK_DONE) begin
                    state_next = brac_pkg::ST_NORMAL;
                end
            end
            brac_pkg::ST_DMA: begin
                if (I_MC_END && I_REFRESH_DUE) begin
                    state_next = brac_pkg::ST_REFRESH;
                end else if (I_MC_END && hold_req) begin
                    state_next = brac_pkg::ST_RELEASE;
                end else if (I_DMA_DONE) begin
                    state_next = brac_pkg::ST_NORMAL;
                end
            end
            brac_pkg::ST_RELEASE: begin
                if (dma_req) begin
                    dma_pend_next = 1'b1;
                end
                if (!hold_req) begin
                    // stays released while hold is low
                    dma_gap_next = dma_pend_reg | dma_req;
                    dma_pend_next = 1'b0;
                    state_next = brac_pkg::ST_NORMAL;
                end
            end
            brac_pkg::ST_SLEEP: begin
                if (hold_req) begin
                    state_next = brac_pkg::ST_RELEASE;
                end else if (irq_req) begin
                    irq_take = 1'b1;
                    state_next = brac_pkg::ST_NORMAL;
                end
            end
            brac_pkg::ST_STOP: begin
                if (hold_req) begin
                    state_next = brac_pkg::ST_RELEASE;
                end else if (irq_req) begin
                    irq_take = 1'b1;
                    state_next = brac_pkg::ST_NORMAL;
                end
            end
            default: begin
                state_next = brac_pkg::ST_NORMAL;
            end
        endcase
    end

    // State and pending DMA bookkeeping
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg <= brac_pkg::ST_NORMAL;
            dma_pend_reg <= 1'b0;
            dma_gap_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            dma_pend_reg <= dma_pend_next;
            dma_gap_reg <= dma_gap_next;
        end
    end

    // Pin levels per cycle kind; registered so outputs come from flops
    logic [6:0] stb;
    logic fst;
    logic bus_float;
    logic data_out;
    logic addr_ones;
    always_comb begin
        stb = brac_pkg::STB_IDLE;
        fst = 1'b1;
        bus_float = 1'b0;
        data_out = 1'b0;
        addr_ones = 1'b0;
        if (state_next == brac_pkg::ST_RELEASE) begin
            bus_float = 1'b1;
        end else if (state_next == brac_pkg::ST_REFRESH) begin
            stb = brac_pkg::STB_REFRESH;
            fst = 1'b0;
        // System stop shows the sleep levels; the bus stays quiet
        end else if (state_next == brac_pkg::ST_SLEEP ||
                     state_next == brac_pkg::ST_STOP) begin
            stb = brac_pkg::STB_SLEEP;
            addr_ones = 1'b1;
        end else begin
            case (I_CYCLE_KIND)
                brac_pkg::CYC_FETCH1: begin
                    stb = brac_pkg::STB_FETCH;
                    fst = 1'b0;
                end
                brac_pkg::CYC_FETCHN: stb = brac_pkg::STB_FETCH;
                brac_pkg::CYC_MEM_RD: stb = brac_pkg::STB_MEM_RD;
                brac_pkg::CYC_MEM_WR: begin
                    stb = brac_pkg::STB_MEM_WR;
                    data_out = 1'b1;
                end
                brac_pkg::CYC_IO_RD: stb = brac_pkg::STB_IO_RD;
                brac_pkg::CYC_IO_WR: begin
                    stb = brac_pkg::STB_IO_WR;
                    data_out = 1'b1;
                end
                brac_pkg::CYC_HALT: begin
                    stb = brac_pkg::STB_HALT & 7'h7E;
                    fst = 1'b0;
                end
                brac_pkg::CYC_ACK_NMI: begin
                    stb = brac_pkg::STB_FETCH;
                    fst = 1'b0;
                end
                brac_pkg::CYC_ACK_IRQ0: begin
                    stb = brac_pkg::STB_ACK_IRQ0;
                    fst = 1'b0;
                end
                brac_pkg::CYC_ACK_OTHER: fst = 1'b0;
                default: stb = brac_pkg::STB_IDLE;
            endcase
        end
    end

    // Output flops; float enables low only in release
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_OPCODE_FETCH_STROBE_N <= 1'b1;
            O_MEMORY_REQUEST_N <= 1'b1;
            O_IO_REQUEST_N <= 1'b1;
            O_READ_N <= 1'b1;
            O_WRITE_N <= 1'b1;
            O_REFRESH_STROBE_N <= 1'b1;
            O_SUSPEND_N <= 1'b1;
            O_MEMORY_REQUEST_OE <= 1'b1;
            O_IO_REQUEST_OE <= 1'b1;
            O_READ_OE <= 1'b1;
            O_WRITE_OE <= 1'b1;
            O_ADDR_OE <= 1'b1;
            O_DATA_OE <= 1'b0;
            O_BUS_HOLD_GRANT_N <= 1'b1;
            O_FIRST_FETCH_STATUS <= 1'b1;
            O_ADDR <= '0;
        end else begin
            O_OPCODE_FETCH_STROBE_N <= stb[6];
            O_MEMORY_REQUEST_N <= stb[5];
            O_IO_REQUEST_N <= stb[4];
            O_READ_N <= stb[3];
            O_WRITE_N <= stb[2];
            O_REFRESH_STROBE_N <= stb[1];
            O_SUSPEND_N <= stb[0];
            O_MEMORY_REQUEST_OE <= !bus_float;
            O_IO_REQUEST_OE <= !bus_float;
            O_READ_OE <= !bus_float;
            O_WRITE_OE <= !bus_float;
            O_ADDR_OE <= !bus_float;
            O_DATA_OE <= data_out;
            O_BUS_HOLD_GRANT_N <= !bus_float;
            O_FIRST_FETCH_STATUS <= fst;
            O_ADDR <= addr_ones ? '1 : I_ADDR;
        end
    end

    // Wait stretch honoured only in accepting states
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_WAIT_STRETCH <= 1'b0;
        end else begin
            O_WAIT_STRETCH <= wait_req &&
                (state_reg == brac_pkg::ST_NORMAL ||
                 state_reg == brac_pkg::ST_WAIT ||
                 state_reg == brac_pkg::ST_ACK ||
                 state_reg == brac_pkg::ST_DMA);
        end
    end

    // Irq pulse and state mirror; the mirror lets the far side follow
    // the sequencer without reaching inside
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_IRQ_TAKEN <= 1'b0;
            O_STATE <= brac_pkg::ST_NORMAL;
        end else begin
            O_IRQ_TAKEN <= irq_take;
            O_STATE <= state_next;
        end
    end

endmodule : brac_top

/* design/brac_pkg.sv */
// Constants and types for the bus request acceptance and status block.
// Assumes one 100 MHz clock; machine cycle boundaries come from the core.
package brac_pkg;

    // Machine cycle kinds reported by the instruction sequencer
    localparam logic [3:0] CYC_FETCH1 = 4'h0;
    localparam logic [3:0] CYC_FETCHN = 4'h1;
    localparam logic [3:0] CYC_MEM_RD = 4'h2;
    localparam logic [3:0] CYC_MEM_WR = 4'h3;
    localparam logic [3:0] CYC_IO_RD = 4'h4;
    localparam logic [3:0] CYC_IO_WR = 4'h5;
    localparam logic [3:0] CYC_INTERNAL = 4'h6;
    localparam logic [3:0] CYC_HALT = 4'h7;
    localparam logic [3:0] CYC_ACK_NMI = 4'h8;
    localparam logic [3:0] CYC_ACK_IRQ0 = 4'h9;
    localparam logic [3:0] CYC_ACK_OTHER = 4'hA;

    // Strobe vector order: fetch, memory_request_n, io_request_n, rd, wr, refresh_strobe_n, suspend
    localparam int STB_W = 7;
    localparam logic [6:0] STB_IDLE = 7'h7F;
    localparam logic [6:0] STB_FETCH = 7'h17; // fetch,memory_request_n,rd low
    localparam logic [6:0] STB_MEM_RD = 7'h57;
    localparam logic [6:0] STB_MEM_WR = 7'h5B;
    localparam logic [6:0] STB_IO_RD = 7'h67;
    localparam logic [6:0] STB_IO_WR = 7'h6B;
    localparam logic [6:0] STB_REFRESH = 7'h5D; // memory_request_n,refresh_strobe_n low
    localparam logic [6:0] STB_ACK_IRQ0 = 7'h2F; // fetch,io_request_n low
    localparam logic [6:0] STB_HALT = 7'h17; // suspend low below
    localparam logic [6:0] STB_SLEEP = 7'h7E;

    // Idle pin levels: wait, hold, dma0, dma1, irq0, irq1, irq2
    localparam logic [6:0] PIN_IDLE = 7'h60;

    // Bus states, one-hot
    typedef enum logic [7:0] {
        ST_NORMAL = 8'h01,
        ST_WAIT = 8'h02,
        ST_REFRESH = 8'h04,
        ST_ACK = 8'h08,
        ST_DMA = 8'h10,
        ST_RELEASE = 8'h20,
        ST_SLEEP = 8'h40,
        ST_STOP = 8'h80
    } brac_state_type;

endpackage : brac_pkg

/* bench/brac_top_sva.sv */
// Assertions on the bus acceptance and status block ports.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module brac_top_sva #(
    parameter int ADDR_W = 16
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_WAIT_N,
    input wire logic I_BUS_HOLD_REQUEST_N,
    input wire logic I_IRQ_LINE_1,
    input wire logic I_MC_END,
    input wire logic I_INSN_END,
    input wire logic O_MEMORY_REQUEST_N,
    input wire logic O_MEMORY_REQUEST_OE,
    input wire logic O_REFRESH_STROBE_N,
    input wire logic O_SUSPEND_N,
    input wire logic O_BUS_HOLD_GRANT_N,
    input wire logic O_FIRST_FETCH_STATUS,
    input wire logic [ADDR_W-1:0] O_ADDR,
    input wire logic O_ADDR_OE,
    input wire logic O_WAIT_STRETCH,
    input wire logic O_IRQ_TAKEN,
    input wire logic [7:0] O_STATE
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    // Masks cover one-hot groups; four samples (honour) and three (refusal) allow for sync lag
    chk_wait_honour: assert property (
        ((O_STATE & 8'h1B) != 0 && !I_WAIT_N)[*4] |-> O_WAIT_STRETCH)
        else $error("wait not honoured");
    chk_wait_refused: assert property (((O_STATE & 8'hE4) != 0)[*3]
        |-> !O_WAIT_STRETCH) else $error("wait honoured in idle state");
    chk_refresh_edge: assert property ($rose(O_STATE == 8'h04)
        |-> $past(I_MC_END) || $past(I_MC_END, 2))
        else $error("refresh began off a cycle boundary");
    chk_asleep_refuse: assert property ((O_STATE & 8'hC0) != 0
        |=> (O_STATE & 8'h14) == 0) else $error("request taken asleep");
    chk_release_edge: assert property ($fell(O_BUS_HOLD_GRANT_N)
        && ($past(O_STATE) & 8'h19) != 0
        |-> $past(I_MC_END) || $past(I_MC_END, 2))
        else $error("bus released off a cycle boundary");
    chk_release_stays: assert property
        ((O_STATE == 8'h20 && !I_BUS_HOLD_REQUEST_N)[*3] |=> O_STATE == 8'h20)
        else $error("release left while hold asserted");
    chk_release_pins: assert property (!O_BUS_HOLD_GRANT_N
        |-> !O_MEMORY_REQUEST_OE && !O_ADDR_OE && O_REFRESH_STROBE_N
        && O_SUSPEND_N) else $error("bus not floated while granted");
    chk_irq_boundary: assert property ($rose(O_IRQ_TAKEN)
        && $past(O_STATE) == 8'h01 |-> $past(I_INSN_END)
        || $past(I_INSN_END, 2)) else $error("irq taken mid instruction");
    chk_sleep_wake: assert property (O_STATE == 8'h40 && I_IRQ_LINE_1
        |-> ##[1:6] O_STATE == 8'h01) else $error("irq did not wake");
    chk_sleep_pins: assert property (O_STATE == 8'h40
        |-> !O_SUSPEND_N && O_MEMORY_REQUEST_N && O_FIRST_FETCH_STATUS
        && (&O_ADDR)) else $error("sleep pin levels wrong");

    // Main scenarios reached
    cov_refresh: cover property ($rose(O_STATE == 8'h04));
    cov_release: cover property ($fell(O_BUS_HOLD_GRANT_N));
    cov_wake: cover property (O_STATE == 8'h80 ##1 O_STATE == 8'h01);
endmodule : brac_top_sva

bind brac_top brac_top_sva #(.ADDR_W(ADDR_W)) i_brac_top_sva (.*);

/* bench/brac_bus_master.sv */
// External bus master model that asks for the bus.
// Assumes the bench raises i_want off the clock edge.
`timescale 1ns/1ps
module brac_bus_master (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_want,
    input wire logic i_grant_n,
    output logic o_hold_n
);
    // Request may only drop after the grant was seen; never drives strobes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hold_n <= 1'b1;
        end else if (i_want) begin
            o_hold_n <= 1'b0;
        end else if (!i_grant_n) begin
            o_hold_n <= 1'b1;
        end
    end
endmodule : brac_bus_master

/* bench/test_bus_request_acceptance_status.sv */
// Self-checking bench for the bus acceptance and status block.
// Assumes stimulus at falling edges and the bus master model beside it.
`timescale 1ns/1ps
module test_bus_request_acceptance_status;
    logic I_CLK, I_RST_N, I_WAIT_N, I_BUS_HOLD_REQUEST_N, want;
    logic I_DMA_REQUEST_CH0, I_DMA_REQUEST_CH1, I_REFRESH_DUE, I_MC_END;
    logic I_IRQ_LINE_0, I_IRQ_LINE_1, I_IRQ_LINE_2, I_INSN_END, I_DMA_DONE;
    logic I_ACK_DONE, I_SLEEP_CMD, I_STOP_CMD, I_IO_FREEZE_MODE;
    logic [3:0] I_CYCLE_KIND;
    logic [15:0] I_ADDR, O_ADDR;
    logic O_OPCODE_FETCH_STROBE_N, O_MEMORY_REQUEST_N, O_MEMORY_REQUEST_OE;
    logic O_IO_REQUEST_N, O_IO_REQUEST_OE, O_READ_N, O_READ_OE, O_WRITE_N;
    logic O_WRITE_OE, O_REFRESH_STROBE_N, O_SUSPEND_N, O_BUS_HOLD_GRANT_N;
    logic O_FIRST_FETCH_STATUS, O_ADDR_OE, O_DATA_OE, O_WAIT_STRETCH;
    logic O_IRQ_TAKEN;
    logic [7:0] O_STATE;
    int num_errors = 0;
    int total_checks = 0;
    int n;
    // Rows: cycle kind beside fetch,memory_request_n,io_request_n,rd,wr,refresh_strobe_n,susp,status,data oe
    logic [3:0] kinds [11] = '{brac_pkg::CYC_FETCH1, brac_pkg::CYC_FETCHN,
        brac_pkg::CYC_MEM_RD, brac_pkg::CYC_MEM_WR, brac_pkg::CYC_IO_RD,
        brac_pkg::CYC_IO_WR, brac_pkg::CYC_INTERNAL, brac_pkg::CYC_HALT,
        brac_pkg::CYC_ACK_NMI, brac_pkg::CYC_ACK_IRQ0,
        brac_pkg::CYC_ACK_OTHER};
    logic [8:0] pexp [11] = '{9'h05C, 9'h05E, 9'h15E, 9'h16F, 9'h19E,
        9'h1AF, 9'h1FE, 9'h058, 9'h05C, 9'h0BC, 9'h1FC};
    wire logic [8:0] pins = {O_OPCODE_FETCH_STROBE_N, O_MEMORY_REQUEST_N,
        O_IO_REQUEST_N, O_READ_N, O_WRITE_N, O_REFRESH_STROBE_N, O_SUSPEND_N,
        O_FIRST_FETCH_STATUS, O_DATA_OE};

    brac_top i_brac_top (.*);
    brac_bus_master i_brac_bus_master (.i_clk(I_CLK), .i_rst_n(I_RST_N),
        .i_want(want), .i_grant_n(O_BUS_HOLD_GRANT_N),
        .o_hold_n(I_BUS_HOLD_REQUEST_N));

    // Free-running 100 MHz clock
    always #5 I_CLK = ~I_CLK;

    task automatic tick(input int k);
        repeat (k) @(negedge I_CLK);
    endtask : tick

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // Bounded poll; a missed state ends the run rather than hanging
    task automatic wstate(input logic [7:0] s);
        for (n = 0; n < 20 && O_STATE !== s; n++) tick(1);
        check("state", 16'(s), 16'(O_STATE));
        if (O_STATE !== s) report_and_stop();
    endtask : wstate

    task automatic do_reset();
        I_RST_N = 1'b0;
        tick(4);
        check("reset state", 16'h0001, 16'(O_STATE));
        check("reset grant", 16'h0001, 16'(O_BUS_HOLD_GRANT_N));
        I_RST_N = 1'b1;
        tick(3);
    endtask : do_reset

    initial begin
        {I_CLK, I_DMA_REQUEST_CH0, I_DMA_REQUEST_CH1, I_REFRESH_DUE} = '0;
        {I_MC_END, I_IRQ_LINE_0, I_IRQ_LINE_1, I_IRQ_LINE_2, want} = '0;
        {I_INSN_END, I_DMA_DONE, I_ACK_DONE, I_SLEEP_CMD, I_STOP_CMD} = '0;
        {I_IO_FREEZE_MODE, I_ADDR} = '0;
        I_WAIT_N = 1'b1;
        I_CYCLE_KIND = brac_pkg::CYC_INTERNAL;
        do_reset();
        check("reset addr", 16'h0000, O_ADDR);
        for (int i = 0; i < 11; i++) begin
            I_CYCLE_KIND = kinds[i];
            I_ADDR = {12'h5A0, 4'(i)};
            tick(3);
            check("pins", 16'(pexp[i]), 16'(pins));
            check("pins", 16'(pexp[i]), 16'(pins));
            check("addr", {12'h5A0, 4'(i)}, O_ADDR);
        end
        I_CYCLE_KIND = brac_pkg::CYC_INTERNAL;
        // Wait honoured in freeze mode, ignored during refresh
        I_IO_FREEZE_MODE = 1'b1;
        I_WAIT_N = 1'b0;
        tick(4);
        check("stretch", 16'h0001, 16'(O_WAIT_STRETCH));
        I_WAIT_N = 1'b1;
        I_IO_FREEZE_MODE = 1'b0;
        wstate(brac_pkg::ST_NORMAL);
        I_REFRESH_DUE = 1'b1;
        pulse(I_MC_END);
        wstate(brac_pkg::ST_REFRESH);
        I_REFRESH_DUE = 1'b0;
        check("refresh pins", 16'h005D, 16'(pins[8:2]));
        I_WAIT_N = 1'b0;
        I_DMA_REQUEST_CH0 = 1'b1;
        tick(4);
        check("stretch", 16'h0000, 16'(O_WAIT_STRETCH));
        // Request dropped: only the refresh's held copy starts the DMA
        I_WAIT_N = 1'b1;
        I_DMA_REQUEST_CH0 = 1'b0;
        tick(3);
        pulse(I_MC_END);
        wstate(brac_pkg::ST_NORMAL);
        pulse(I_MC_END);
        wstate(brac_pkg::ST_DMA);
        pulse(I_DMA_DONE);
        wstate(brac_pkg::ST_NORMAL);
        // Hold: float, stay released, DMA held until after release
        want = 1'b1;
        tick(3);
        pulse(I_MC_END);
        wstate(brac_pkg::ST_RELEASE);
        check("float", 16'h0007, 16'({O_MEMORY_REQUEST_OE, O_IO_REQUEST_OE,
            O_READ_OE, O_WRITE_OE, O_ADDR_OE, O_BUS_HOLD_GRANT_N,
            O_OPCODE_FETCH_STROBE_N, O_REFRESH_STROBE_N,
            O_SUSPEND_N}));
        I_DMA_REQUEST_CH1 = 1'b1;
        repeat (3) pulse(I_MC_END);
        check("state", 16'h0020, 16'(O_STATE));
        I_DMA_REQUEST_CH1 = 1'b0;
        want = 1'b0;
        wstate(brac_pkg::ST_NORMAL);
        pulse(I_MC_END);
        wstate(brac_pkg::ST_DMA);
        do_reset();
        // Irq waits for the instruction boundary
        I_IRQ_LINE_0 = 1'b1;
        tick(3);
        pulse(I_MC_END);
        tick(2);
        check("state", 16'h0001, 16'(O_STATE));
        pulse(I_INSN_END);
        for (n = 0; n < 8 && O_IRQ_TAKEN !== 1'b1; n++) tick(1);
        check("irq taken", 16'h0001, 16'(O_IRQ_TAKEN));
        if (O_IRQ_TAKEN !== 1'b1) report_and_stop();
        I_IRQ_LINE_0 = 1'b0;
        pulse(I_ACK_DONE);
        wstate(brac_pkg::ST_NORMAL);
        // Sleep: pins, refusals, wake by irq and by hold
        I_SLEEP_CMD = 1'b1;
        pulse(I_MC_END);
        wstate(brac_pkg::ST_SLEEP);
        I_SLEEP_CMD = 1'b0;
        check("sleep pins", 16'h00FD, 16'(pins[8:1]));
        check("sleep addr", 16'hFFFF, O_ADDR);
        {I_DMA_REQUEST_CH0, I_REFRESH_DUE} = 2'h3;
        tick(3);
        pulse(I_MC_END);
        tick(2);
        check("state", 16'h0040, 16'(O_STATE));
        {I_DMA_REQUEST_CH0, I_REFRESH_DUE} = 2'h0;
        tick(3);
        I_IRQ_LINE_1 = 1'b1;
        wstate(brac_pkg::ST_NORMAL);
        I_IRQ_LINE_1 = 1'b0;
        tick(3);
        I_SLEEP_CMD = 1'b1;
        pulse(I_MC_END);
        wstate(brac_pkg::ST_SLEEP);
        I_SLEEP_CMD = 1'b0;
        want = 1'b1;
        wstate(brac_pkg::ST_RELEASE);
        want = 1'b0;
        wstate(brac_pkg::ST_NORMAL);
        I_STOP_CMD = 1'b1;
        pulse(I_MC_END);
        wstate(brac_pkg::ST_STOP);
        I_STOP_CMD = 1'b0;
        I_IRQ_LINE_2 = 1'b1;
        wstate(brac_pkg::ST_NORMAL);
        I_IRQ_LINE_2 = 1'b0;
        report_and_stop();
    end
endmodule : test_bus_request_acceptance_status
